/* pkg/tmi_pkg.sv */
// Package for the translation buffer management instruction unit.
// Assumes a 32-bit core with big-endian bit numbering in the instruction word.
package tmi_pkg;

    // Instruction decode fields
    localparam logic [5:0] TMI_PRIMARY_OP = 6'h1F;
    localparam logic [9:0] TMI_XO_SEARCH = 10'h392;
    localparam logic [9:0] TMI_XO_WRITE = 10'h3D2;
    localparam logic [9:0] TMI_XO_READ = 10'h3B2;
    localparam logic [9:0] TMI_XO_SYNC = 10'h236;

    // Array geometry and word select
    localparam int TMI_ENTRIES = 64;
    localparam int TMI_IDX_W = 6;
    localparam int TMI_TID_W = 8;
    localparam logic [1:0] TMI_WS_MAX = 2'h2;

    // Parity field positions in little-endian numbering of the data word
    localparam int TMI_PAR0_LO = 0;
    localparam int TMI_WORD1_PARITY_LO = 8;
    localparam int TMI_WORD2_PARITY_LO = 30;

    // Reset values
    localparam logic [3:0] TMI_CR0_RST = 4'h0;

    // Operation codes
    typedef enum logic [3:0] {
        TMI_OP_NONE = 4'h1,
        TMI_OP_SEARCH = 4'h2,
        TMI_OP_WRITE = 4'h4,
        TMI_OP_READ = 4'h8
    } tmi_op_type;

    // Search identifier and address space from the control register
    typedef struct packed {
        logic [TMI_TID_W-1:0] search_translation_ident;
        logic search_address_space;
    } tmi_mmu_control_reg_type;

    // One entry of the translation array
    typedef struct packed {
        logic valid;
        logic addr_space;
        logic [21:0] epn;
        logic [TMI_TID_W-1:0] entry_translation_ident;
        logic [31:0] word0;
        logic [31:0] word1;
        logic [31:0] word2;
    } tmi_entry_type;

endpackage

/* logic/tmi_unit.sv */
// Translation buffer management unit: search, entry write, entry read, sync.
// Assumes the pipeline presents one decoded instruction word a cycle with
// register operands already read; results are returned one cycle later.
// Behaviour
// - Address is index plus base, base zero allowed
// - Search matches valid entry, identifier, address space
// - Hit writes six-bit index, upper bits zero
// - Miss leaves target value arbitrary
// - Record bit sets condition field from hit
// - Read-to-search identifier needs software sync
// - Read identifier forwarded to write and move-from
// - Translation sync is a no-operation
// - Sync privileged, works without translation
// - Entry write privileged, rejected in user mode
// - Write replaces selected word, identifier on zero
// - Write computes parity, ignores source parity bits
// - Write index from base register
// - Word select above two is invalid
// - Bit 31 on write or sync leaves condition field unchanged
// - Decode primary and extended opcodes
// - Read word zero copies identifier to control
`timescale 1ns/100ps
module tmi_unit
    import tmi_pkg::*;
#(
    parameter int ENTRIES = TMI_ENTRIES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Instruction issue
    input wire logic instr_valid,
    input wire logic [31:0] instr_word,
    input wire logic user_mode,
    // Register operands
    input wire logic [31:0] base_gpr_val,
    input wire logic [31:0] index_gpr_val,
    input wire logic [31:0] source_gpr_val,
    input wire logic summary_overflow_flag,
    // Control register write from move-to
    input wire logic mmu_control_reg_wr,
    input wire tmi_pkg::tmi_mmu_control_reg_type mmu_control_reg_wdata,
    // Results
    output logic target_wr_r,
    output logic [4:0] target_gpr_r,
    output logic [31:0] target_data_r,
    output logic cr0_wr_r,
    output logic [3:0] condition_field_zero_r,
    output logic priv_fault_r,
    output logic invalid_form_r,
    output tmi_pkg::tmi_mmu_control_reg_type mmu_control_reg_r,
    output tmi_pkg::tmi_mmu_control_reg_type mmu_control_reg_search_view_r
);
    import tmi_pkg::*;

    tmi_entry_type tlb_r [ENTRIES];
    tmi_mmu_control_reg_type mmu_control_reg_nxt;

    // Field decode
    wire logic [5:0] f_op = instr_word[31:26];
    wire logic [4:0] f_rt = instr_word[25:21];
    wire logic [4:0] f_ra = instr_word[20:16];
    wire logic [1:0] f_ws = instr_word[12:11];
    wire logic [9:0] f_xo = instr_word[10:1];
    wire logic f_rc = instr_word[0];
    // Word select field is five bits wide; only codes zero to two are legal
    wire logic [2:0] f_ws_hi = instr_word[15:13];
    wire logic ws_ok = f_ws_hi == 3'h0 && f_ws <= TMI_WS_MAX;

    // Classify the instruction word
    function automatic tmi_op_type decode_op(input logic [5:0] op, input logic [9:0] xo);
        tmi_op_type r;
        r = TMI_OP_NONE;
        if (op == TMI_PRIMARY_OP) begin
            if (xo == TMI_XO_SEARCH) r = TMI_OP_SEARCH;
            else if (xo == TMI_XO_WRITE) r = TMI_OP_WRITE;
            else if (xo == TMI_XO_READ) r = TMI_OP_READ;
        end
        return r;
    endfunction

    // Even-parity over a word with its parity bits masked out
    function automatic logic [1:0] word2_parity(input logic [31:0] d);
        return {^d[31:16], ^d[15:0]};
    endfunction

    wire tmi_op_type op_kind = decode_op(f_op, f_xo);
    wire logic is_sync = instr_valid && f_op == TMI_PRIMARY_OP && f_xo == TMI_XO_SYNC;
    wire logic privileged = op_kind != TMI_OP_NONE || is_sync;
    wire logic fault = instr_valid && privileged && user_mode;
    wire logic go = instr_valid && !fault;
    wire logic do_search = go && op_kind == TMI_OP_SEARCH;
    wire logic do_write = go && op_kind == TMI_OP_WRITE && ws_ok;
    wire logic do_read = go && op_kind == TMI_OP_READ && ws_ok;
    wire logic bad_ws = go && (op_kind == TMI_OP_WRITE || op_kind == TMI_OP_READ)
        && !ws_ok;

    // Effective address: base is zero when the field is zero
    wire logic [31:0] eff_base = (f_ra == 5'h00) ? 32'h0000_0000 : base_gpr_val;
    wire logic [31:0] eff_addr = eff_base + index_gpr_val;
    wire logic [TMI_IDX_W-1:0] wr_idx = base_gpr_val[TMI_IDX_W-1:0];

    // Search sees only the committed identifier, not a pending read update
    logic [ENTRIES-1:0] hit_vec;
    genvar gi;
    generate
        for (gi = 0; gi < ENTRIES; gi++) begin : g_match
            assign hit_vec[gi] = tlb_r[gi].valid
                && tlb_r[gi].epn == eff_addr[31:10]
                && tlb_r[gi].addr_space == mmu_control_reg_search_view_r.search_address_space
                && tlb_r[gi].entry_translation_ident
                   == mmu_control_reg_search_view_r.search_translation_ident;
        end
    endgenerate

    // Lowest matching index
    logic [TMI_IDX_W-1:0] hit_idx;
    always_comb begin
        hit_idx = '0;
        for (int i = ENTRIES - 1; i >= 0; i--) begin
            if (hit_vec[i]) hit_idx = TMI_IDX_W'(i);
        end
    end
    wire logic hit_any = |hit_vec;

    // Write data with parity positions recomputed from the other bits
    wire logic [31:0] src0 = {source_gpr_val[31:2], 2'b00};
    wire logic [31:0] src1 = {source_gpr_val[31:10], 2'b00, source_gpr_val[7:0]};
    wire logic [31:0] src2 = {2'b00, source_gpr_val[29:0]};
    wire logic [31:0] wd0 = {src0[31:2], word2_parity(src0)};
    wire logic [31:0] wd1 = {src1[31:10], word2_parity(src1), src1[7:0]};
    wire logic [31:0] wd2 = {word2_parity(src2), src2[29:0]};

    // Read of the selected entry for the identifier update
    wire tmi_entry_type rd_ent = tlb_r[wr_idx];

    // Control register next value: move-to, or read with word select zero
    always_comb begin
        mmu_control_reg_nxt = mmu_control_reg_r;
        if (mmu_control_reg_wr) mmu_control_reg_nxt = mmu_control_reg_wdata;
        if (do_read && f_ws == 2'h0) begin
            mmu_control_reg_nxt.search_translation_ident = rd_ent.entry_translation_ident;
        end
    end

    // Architected control register; forwards to writes and move-from at once
    always_ff @(posedge ref_clk) begin
        if (rst) mmu_control_reg_r <= '0;
        else mmu_control_reg_r <= mmu_control_reg_nxt;
    end

    // Search view lags by a cycle; software sync covers the gap
    always_ff @(posedge ref_clk) begin
        if (rst) mmu_control_reg_search_view_r <= '0;
        else mmu_control_reg_search_view_r <= mmu_control_reg_r;
    end

    // Array write of the selected word
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int i = 0; i < ENTRIES; i++) tlb_r[i] <= '0;
        end else if (do_write) begin
            unique case (f_ws)
                2'h0: begin
                    tlb_r[wr_idx].word0 <= wd0;
                    tlb_r[wr_idx].epn <= wd0[31:10];
                    tlb_r[wr_idx].valid <= wd0[9];
                    tlb_r[wr_idx].addr_space <= wd0[8];
                    tlb_r[wr_idx].entry_translation_ident
                        <= mmu_control_reg_r.search_translation_ident;
                end
                2'h1: tlb_r[wr_idx].word1 <= wd1;
                2'h2: tlb_r[wr_idx].word2 <= wd2;
                default: tlb_r[wr_idx].word2 <= tlb_r[wr_idx].word2;
            endcase
        end
    end

    // Target and condition results
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            target_wr_r <= 1'b0;
            target_gpr_r <= 5'h00;
            target_data_r <= 32'h0000_0000;
            cr0_wr_r <= 1'b0;
            condition_field_zero_r <= TMI_CR0_RST;
            priv_fault_r <= 1'b0;
            invalid_form_r <= 1'b0;
        end else begin
            target_wr_r <= do_search;
            target_gpr_r <= f_rt;
            target_data_r <= {26'h0, hit_idx};
            cr0_wr_r <= do_search && f_rc;
            if (do_search && f_rc) begin
                condition_field_zero_r <= {summary_overflow_flag, hit_any, 2'b00};
            end
            priv_fault_r <= fault;
            invalid_form_r <= bad_ws;
        end
    end

    // Checks
    sequence s_search_rc;
        do_search && f_rc;
    endsequence

    chk_cr0_hit: assert property (@(posedge ref_clk) disable iff (rst)
        s_search_rc |=> cr0_wr_r && condition_field_zero_r[2] == $past(hit_any)
            && condition_field_zero_r[1:0] == 2'b00)
        else $error("condition field not set from search");
    chk_cr0_keep: assert property (@(posedge ref_clk) disable iff (rst)
        !(do_search && f_rc) |=> $stable(condition_field_zero_r))
        else $error("condition field changed without record");
    chk_hit_index: assert property (@(posedge ref_clk) disable iff (rst)
        do_search && hit_any |=> target_wr_r && target_data_r[31:6] == 26'h0)
        else $error("search hit index malformed");
    chk_user_fault: assert property (@(posedge ref_clk) disable iff (rst)
        instr_valid && user_mode && op_kind == TMI_OP_WRITE |=> priv_fault_r && !target_wr_r)
        else $error("user write not rejected");
    chk_sync_nop: assert property (@(posedge ref_clk) disable iff (rst)
        is_sync |=> !target_wr_r && !cr0_wr_r)
        else $error("sync produced a result");
    chk_read_ident: assert property (@(posedge ref_clk) disable iff (rst)
        do_read && f_ws == 2'h0 && !mmu_control_reg_wr |=> mmu_control_reg_r.search_translation_ident
            == $past(rd_ent.entry_translation_ident))
        else $error("read did not update identifier");
    chk_write_ident: assert property (@(posedge ref_clk) disable iff (rst)
        do_write && f_ws == 2'h0 |=> tlb_r[$past(wr_idx)].entry_translation_ident
            == $past(mmu_control_reg_r.search_translation_ident))
        else $error("write did not load identifier");
    chk_bad_ws: assert property (@(posedge ref_clk) disable iff (rst)
        bad_ws |=> invalid_form_r && !target_wr_r && !cr0_wr_r)
        else $error("invalid word select not flagged");
    chk_ea_zero: assert property (@(posedge ref_clk) disable iff (rst)
        do_search && f_ra == 5'h00 |-> eff_addr == index_gpr_val)
        else $error("base not zero for field zero");

    // Steps of the write, search and refusal behaviours
    sequence s_write_w0;
        do_write && f_ws == 2'h0;
    endsequence
    sequence s_write_w1;
        do_write && f_ws == 2'h1;
    endsequence
    sequence s_write_w2;
        do_write && f_ws == 2'h2;
    endsequence
    sequence s_search_miss;
        do_search && f_rc && !hit_any;
    endsequence
    sequence s_search_hit;
        do_search && hit_any;
    endsequence
    sequence s_quiet;
        (fault || bad_ws || is_sync) && !mmu_control_reg_wr;
    endsequence

    // Word zero carries the tag fields straight from the source
    chk_w0_tag: assert property (@(posedge ref_clk) disable iff (rst)
        s_write_w0 |=> tlb_r[$past(wr_idx)].epn == $past(source_gpr_val[31:10])
            && tlb_r[$past(wr_idx)].valid == $past(source_gpr_val[9])
            && tlb_r[$past(wr_idx)].addr_space == $past(source_gpr_val[8]))
        else $error("word zero tag fields not written");

    // Data bits land unchanged; only the parity positions differ
    chk_w0_data: assert property (@(posedge ref_clk) disable iff (rst)
        s_write_w0 |=> tlb_r[$past(wr_idx)].word0[31:2] == $past(source_gpr_val[31:2]))
        else $error("word zero data not written");
    chk_w1_data: assert property (@(posedge ref_clk) disable iff (rst)
        s_write_w1 |=> tlb_r[$past(wr_idx)].word1[31:10] == $past(source_gpr_val[31:10])
            && tlb_r[$past(wr_idx)].word1[7:0] == $past(source_gpr_val[7:0]))
        else $error("word one data not written");
    chk_w2_data: assert property (@(posedge ref_clk) disable iff (rst)
        s_write_w2 |=> tlb_r[$past(wr_idx)].word2[29:0] == $past(source_gpr_val[29:0]))
        else $error("word two data not written");

    // Each parity bit covers its half word with the parity positions left out
    chk_w0_parity: assert property (@(posedge ref_clk) disable iff (rst)
        s_write_w0 |=> tlb_r[$past(wr_idx)].word0[1] == ^tlb_r[$past(wr_idx)].word0[31:16]
            && tlb_r[$past(wr_idx)].word0[0] == ^tlb_r[$past(wr_idx)].word0[15:2])
        else $error("word zero parity wrong");
    chk_w1_parity: assert property (@(posedge ref_clk) disable iff (rst)
        s_write_w1 |=> tlb_r[$past(wr_idx)].word1[9] == ^tlb_r[$past(wr_idx)].word1[31:16]
            && tlb_r[$past(wr_idx)].word1[8] == ^{tlb_r[$past(wr_idx)].word1[15:10],
            tlb_r[$past(wr_idx)].word1[7:0]})
        else $error("word one parity wrong");
    chk_w2_parity: assert property (@(posedge ref_clk) disable iff (rst)
        s_write_w2 |=> tlb_r[$past(wr_idx)].word2[31] == ^tlb_r[$past(wr_idx)].word2[29:16]
            && tlb_r[$past(wr_idx)].word2[30] == ^tlb_r[$past(wr_idx)].word2[15:0])
        else $error("word two parity wrong");

    // A miss clears the hit bit, and the overflow copy follows the flag
    chk_miss_flag: assert property (@(posedge ref_clk) disable iff (rst)
        s_search_miss |=> cr0_wr_r && !condition_field_zero_r[2])
        else $error("miss left hit bit set");
    chk_so_copy: assert property (@(posedge ref_clk) disable iff (rst)
        s_search_rc |=> condition_field_zero_r[3] == $past(summary_overflow_flag))
        else $error("overflow copy wrong");

    // The reported entry is valid and carries the searched identifier
    chk_hit_match: assert property (@(posedge ref_clk) disable iff (rst)
        s_search_hit |=> $past(tlb_r[hit_idx].valid)
            && $past(tlb_r[hit_idx].entry_translation_ident)
            == $past(mmu_control_reg_search_view_r.search_translation_ident)
            && target_data_r[5:0] == $past(hit_idx))
        else $error("hit entry does not match");

    // Without the record bit only the target register is written
    chk_rc0_target: assert property (@(posedge ref_clk) disable iff (rst)
        do_search && !f_rc |=> target_wr_r && !cr0_wr_r)
        else $error("search without record touched condition");
    chk_target_num: assert property (@(posedge ref_clk) disable iff (rst)
        do_search |=> target_gpr_r == $past(f_rt))
        else $error("search target number wrong");

    // Search view trails the control register by one cycle, two cycles after the move-to
    chk_view_lag: assert property (@(posedge ref_clk) disable iff (rst)
        mmu_control_reg_wr |=> ##1 mmu_control_reg_search_view_r == $past(mmu_control_reg_r))
        else $error("search view does not trail control");

    // Refused, invalid and sync instructions leave state and results alone
    chk_quiet_state: assert property (@(posedge ref_clk) disable iff (rst)
        s_quiet |=> $stable(mmu_control_reg_r) && !target_wr_r && !cr0_wr_r)
        else $error("quiet instruction changed state");
    chk_refused_entry: assert property (@(posedge ref_clk) disable iff (rst)
        fault || bad_ws |=> tlb_r[$past(wr_idx)] == $past(tlb_r[wr_idx]))
        else $error("refused instruction changed an entry");

    // Privilege applies to sync and search as well
    chk_sync_fault: assert property (@(posedge ref_clk) disable iff (rst)
        instr_valid && user_mode && is_sync |=> priv_fault_r)
        else $error("user sync not rejected");
    chk_search_fault: assert property (@(posedge ref_clk) disable iff (rst)
        instr_valid && user_mode && op_kind == TMI_OP_SEARCH |=> priv_fault_r && !cr0_wr_r)
        else $error("user search not rejected");

    // Bit 31 on write or sync leaves the condition field as it was
    chk_bit31_keep: assert property (@(posedge ref_clk) disable iff (rst)
        (do_write || is_sync) && f_rc |=> $stable(condition_field_zero_r) && !cr0_wr_r)
        else $error("bit 31 changed condition field");

endmodule // tmi_unit

/* dv/tmi_gpr_model.sv */
// Partner model: register file that takes the unit's target writes.
// Assumes at most one target write pulse per ref_clk cycle.
`timescale 1ns/100ps
module tmi_gpr_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Target write port
    input wire logic wr,
    input wire logic [4:0] num,
    input wire logic [31:0] data
);
    logic [31:0] gpr_r [32];
    // Store each search result in its target register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            gpr_r <= '{default: 32'h0};
        end else if (wr) begin
            gpr_r[num] <= data;
        end
    end
endmodule // tmi_gpr_model

/* dv/test_tmi_unit.sv */
// Testbench for the translation buffer management unit.
// Assumes results stand by the falling edge after the edge that takes the instruction.
`timescale 1ns/100ps
module test_tmi_unit;
    import tmi_pkg::*;
    localparam logic [31:0] EA = 32'h1234_5400;
    localparam logic [31:0] EB = 32'h0076_5800;
    logic ref_clk, rst, instr_valid, user_mode, summary_overflow_flag, mmu_control_reg_wr;
    logic [31:0] instr_word, base_gpr_val, index_gpr_val, source_gpr_val;
    tmi_mmu_control_reg_type mmu_control_reg_wdata, mmu_control_reg_r, mmu_control_reg_search_view_r;
    logic target_wr_r, cr0_wr_r, priv_fault_r, invalid_form_r;
    logic [4:0] target_gpr_r;
    logic [31:0] target_data_r;
    logic [3:0] condition_field_zero_r;
    int err_count = 0;
    int checks_done = 0;
    tmi_unit DUT (.ref_clk, .rst, .instr_valid, .instr_word, .user_mode, .base_gpr_val,
        .index_gpr_val, .source_gpr_val, .summary_overflow_flag, .mmu_control_reg_wr, .mmu_control_reg_wdata,
        .target_wr_r, .target_gpr_r, .target_data_r, .cr0_wr_r, .condition_field_zero_r,
        .priv_fault_r, .invalid_form_r, .mmu_control_reg_r, .mmu_control_reg_search_view_r);
    tmi_gpr_model gprs (.ref_clk, .rst, .wr(target_wr_r), .num(target_gpr_r),
        .data(target_data_r));
    // 125 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // Count a comparison, report a mismatch
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    // Instruction word from its fields
    function automatic logic [31:0] mk(input logic [9:0] xo, input logic [4:0] rt, ra, f,
        input logic rc);
        return {TMI_PRIMARY_OP, rt, ra, f, xo, rc};
    endfunction
    // Present at a falling edge; returns when the results stand, valid still high
    task automatic issue(input logic [31:0] w, input logic [31:0] b, input logic [31:0] x);
        instr_word = w;
        base_gpr_val = b;
        index_gpr_val = x;
        instr_valid = 1'b1;
        @(negedge ref_clk);
    endtask
    task automatic idle();
        instr_valid = 1'b0;
        @(negedge ref_clk);
    endtask
    // Load the control register, then let the search view catch up
    task automatic setcr(input logic [8:0] v);
        mmu_control_reg_wdata = v;
        mmu_control_reg_wr = 1'b1;
        @(negedge ref_clk);
        mmu_control_reg_wr = 1'b0;
        @(negedge ref_clk);
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // User mode refusals, then bad word selects three and four to a low entry
    task automatic t_priv();
        user_mode = 1'b1;
        source_gpr_val = {EA[31:10], 10'h303};
        issue(mk(TMI_XO_WRITE, 5'h1, 5'h4, 5'h0, 1'b0), 32'h5, 32'h0);
        chk("wr fault", 1, priv_fault_r);
        issue(mk(TMI_XO_SYNC, 5'h0, 5'h0, 5'h0, 1'b0), 32'h0, 32'h0);
        chk("sync fault", 1, priv_fault_r);
        issue(mk(TMI_XO_SEARCH, 5'h7, 5'h0, 5'h2, 1'b1), 32'h0, EA);
        chk("sx fault", 1, priv_fault_r);
        chk("sx no cr", 0, cr0_wr_r);
        user_mode = 1'b0;
        issue(mk(TMI_XO_WRITE, 5'h1, 5'h4, 5'h3, 1'b0), 32'h3, 32'h0);
        chk("bad ws", 1, invalid_form_r);
        issue(mk(TMI_XO_WRITE, 5'h1, 5'h4, 5'h4, 1'b0), 32'h3, 32'h0);
        chk("ws four", 1, invalid_form_r);
        idle();
    endtask
    // Write entry 5, then hit, base-zero hit, miss and no-record searches
    task automatic t_search();
        summary_overflow_flag = 1'b1;
        issue(mk(TMI_XO_WRITE, 5'h1, 5'h4, 5'h0, 1'b0), 32'h5, 32'h0);
        chk("wr ok", 0, {priv_fault_r, invalid_form_r, target_wr_r});
        idle();
        issue(mk(TMI_XO_SEARCH, 5'h7, 5'h4, 5'h2, 1'b1), EA - 32'h100, 32'h100);
        chk("hit idx", 5, target_data_r);
        chk("hit dst", 7, target_gpr_r);
        chk("hit cr", 4'hC, condition_field_zero_r);
        summary_overflow_flag = 1'b0;
        issue(mk(TMI_XO_SEARCH, 5'h9, 5'h0, 5'h2, 1'b1), 32'hFFFF_0000, EA);
        chk("ra0 hit", 5, target_data_r);
        chk("ra0 cr", 4'h4, condition_field_zero_r);
        summary_overflow_flag = 1'b1;
        issue(mk(TMI_XO_SEARCH, 5'h9, 5'h0, 5'h2, 1'b1), 32'h0, EA + 32'h400);
        chk("miss cr", 4'h8, condition_field_zero_r);
        issue(mk(TMI_XO_SEARCH, 5'hA, 5'h0, 5'h2, 1'b0), 32'h0, EA);
        chk("rc0 cr", 4'h8, condition_field_zero_r);
        chk("rc0 wr", 1, {cr0_wr_r, target_wr_r});
        chk("gpr file", 5, gprs.gpr_r[7]);
        idle();
    endtask
    // Identifier from a read reaches a back-to-back write and the move-from view
    task automatic t_ident();
        setcr({8'h3C, 1'b1});
        source_gpr_val = {EB[31:10], 10'h300};
        issue(mk(TMI_XO_WRITE, 5'h1, 5'h4, 5'h0, 1'b0), 32'h6, 32'h0);
        idle();
        setcr({8'h5A, 1'b1});
        issue(mk(TMI_XO_READ, 5'h2, 5'h4, 5'h0, 1'b0), 32'h6, 32'h0);
        chk("rd ident", 9'h079, mmu_control_reg_r);
        chk("view lag", 9'h0B5, mmu_control_reg_search_view_r);
        issue(mk(TMI_XO_WRITE, 5'h1, 5'h4, 5'h0, 1'b0), 32'h2, 32'h0);
        chk("mf ident", 9'h079, mmu_control_reg_r);
        issue(mk(TMI_XO_SYNC, 5'h0, 5'h0, 5'h0, 1'b1), 32'h0, 32'h0);
        chk("sync quiet", 0, {priv_fault_r, target_wr_r, cr0_wr_r});
        issue(mk(TMI_XO_SEARCH, 5'h3, 5'h0, 5'h2, 1'b1), 32'h0, EB);
        chk("fwd hit", 2, target_data_r);
        issue(mk(TMI_XO_SEARCH, 5'h3, 5'h0, 5'h2, 1'b1) ^ 32'h0400_0000, 32'h0, EB);
        chk("bad op", 0, {target_wr_r, cr0_wr_r});
        idle();
    endtask
    // Main sequence
    initial begin
        rst = 1'b1;
        instr_valid = 1'b0;
        instr_word = 32'h0;
        user_mode = 1'b0;
        summary_overflow_flag = 1'b0;
        mmu_control_reg_wr = 1'b0;
        mmu_control_reg_wdata = '0;
        base_gpr_val = 32'h0;
        index_gpr_val = 32'h0;
        source_gpr_val = 32'h0;
        repeat (4) @(negedge ref_clk);
        rst = 1'b0;
        chk("rst out", 0, {condition_field_zero_r, mmu_control_reg_r});
        setcr({8'h5A, 1'b1});
        chk("cr load", 9'h0B5, mmu_control_reg_r);
        chk("cr view", 9'h0B5, mmu_control_reg_search_view_r);
        t_priv();
        t_search();
        t_ident();
        stop_test();
    end
    // Cut a hung run short
    initial begin
        #100000;
        err_count++;
        stop_test();
    end
endmodule // test_tmi_unit
